/* File: rtl/ebc_phase_ctrl.sv */
// External bus cycle controller that runs each cycle through five programmable phases.
//
// Contract
// - Each bus cycle runs setup, command, write setup, access, hold in that order.
// - Phase lengths come from the selected chip select; command delay is 0 to 3.
// - Access lasts 1 to 32 cycles; the external ready may stretch it.
// - Address setup is 1 or 2 cycles, at most 5 with extension.
// - Setup gains 0 to 3 extra cycles only when the window changes.
// - Write setup or mux turnaround phase lasts 0 or 1 cycle.
// - Address and write data stay stable for 0 to 3 hold cycles.
// - The system clock drives the reference clock output with fast driver enabled.
// - All phase lengths count in system clock periods.
module ebc_phase_ctrl (
  // System clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Clock of the external module, which launches the ready handshake.
  input wire logic linkClk,
  // Timing configuration, one entry per chip select.
  input wire ebc_pkg::ebc_timing_t [ebc_pkg::CS_N-1:0] chip_select_timing_config,
  // Reference clock enable and output.
  input wire logic refClkEnable,
  output logic clock_output_signal,
  output logic refClkFastDrive,
  // Request handshake from the core.
  input wire logic reqValid,
  input wire ebc_pkg::ebc_req_t reqIn,
  output logic reqReady,
  // Completion toward the core.
  output logic doneValid,
  output logic [ebc_pkg::DATA_W-1:0] rdData,
  // External bus pins.
  output logic [ebc_pkg::ADDR_W-1:0] busAddr,
  output logic [ebc_pkg::CS_N-1:0] busCs,
  output logic busRdStrobe,
  output logic busWrStrobe,
  output logic [ebc_pkg::DATA_W-1:0] busDataOut,
  output logic busDataOe,
  input wire logic [ebc_pkg::DATA_W-1:0] busDataIn,
  input wire logic busReady,
  // Current phase, for observation.
  output ebc_pkg::ebc_phase_t phase
);
  import ebc_pkg::*;

  ebc_phase_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CS_W-1:0] lastCs_reg;
  ebc_timing_t cur_reg;
  ebc_req_t req_reg;
  logic readyLink_reg;
  logic readySync;
  logic [DATA_W-1:0] dataSync;

  // Ready is taken on the link clock, then crossed as a level into the system domain.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      readyLink_reg <= 1'b0;
    end else begin
      readyLink_reg <= busReady;
    end
  end

  ebc_sync2 #(.WIDTH(1)) u_ready_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(readyLink_reg),
    .syncOut(readySync)
  );

  // Read data pins are synchronised too, so the capture costs two cycles of latency.
  ebc_sync2 #(.WIDTH(DATA_W)) u_data_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(busDataIn),
    .syncOut(dataSync)
  );

  // Phase lengths of the incoming request and of the latched cycle, in cycles.
  wire ebc_timing_t newCfg = chip_select_timing_config[reqIn.chipSel];
  wire winChange = reqIn.chipSel != lastCs_reg;
  wire [CNT_W-1:0] newSetupLen = SETUP_BASE_MIN + {5'h00, newCfg.setupLong}
    + (winChange ? {4'h0, newCfg.setupExt} : CNT_RESET);
  wire [CNT_W-1:0] cmdLen = {4'h0, cur_reg.cmdDelay};
  wire [CNT_W-1:0] wrsuLen = {5'h00, cur_reg.wrSetup};
  wire [CNT_W-1:0] accLen = {1'b0, cur_reg.accessLen} + ACCESS_MIN;
  wire [CNT_W-1:0] holdLen = {4'h0, cur_reg.holdLen};
  wire accept = reqValid && (state_reg == PH_IDLE);
  wire lastCyc = cnt_reg == CNT_RESET;
  wire accessEnd = lastCyc && (!cur_reg.readyEn || readySync);

  // Phases of zero length are skipped, keeping the fixed order.
  wire ebc_phase_t afterCmd = (wrsuLen != CNT_RESET) ? PH_WRSU : PH_ACCESS;
  wire ebc_phase_t afterSetup = (cmdLen != CNT_RESET) ? PH_CMD : afterCmd;
  wire ebc_phase_t afterAccess = (holdLen != CNT_RESET) ? PH_HOLD : PH_IDLE;

  assign reqReady = state_reg == PH_IDLE;
  assign phase = state_reg;

  // The reference clock is the system clock itself, routed to the pin.
  assign clock_output_signal = ref_clk & refClkEnable;
  assign refClkFastDrive = refClkEnable;

  // Next phase and the count of cycles left in it.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      PH_IDLE: begin
        if (accept) begin
          state_next = PH_SETUP;
          cnt_next = newSetupLen - 6'h01;
        end
      end
      PH_SETUP, PH_CMD, PH_WRSU, PH_HOLD: begin
        if (!lastCyc) begin
          cnt_next = cnt_reg - 6'h01;
        end else begin
          if (state_reg == PH_SETUP) begin
            state_next = afterSetup;
          end else if (state_reg == PH_CMD) begin
            state_next = afterCmd;
          end else if (state_reg == PH_WRSU) begin
            state_next = PH_ACCESS;
          end else begin
            state_next = PH_IDLE;
          end
          unique case (state_next)
            PH_CMD: cnt_next = cmdLen - 6'h01;
            PH_WRSU: cnt_next = wrsuLen - 6'h01;
            PH_ACCESS: cnt_next = accLen - 6'h01;
            default: cnt_next = CNT_RESET;
          endcase
        end
      end
      PH_ACCESS: begin
        if (!lastCyc) begin
          cnt_next = cnt_reg - 6'h01;
        end else if (accessEnd) begin
          state_next = afterAccess;
          cnt_next = (holdLen != CNT_RESET) ? holdLen - 6'h01 : CNT_RESET;
        end
      end
      default: begin
        state_next = PH_IDLE;
        cnt_next = CNT_RESET;
      end
    endcase
  end

  // Phase state and counter.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PH_IDLE;
      cnt_reg <= CNT_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // The request and its timing are latched so address and data stay put through hold.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '0;
      cur_reg <= '0;
      lastCs_reg <= LAST_CS_RESET;
    end else if (accept) begin
      req_reg <= reqIn;
      cur_reg <= newCfg;
      lastCs_reg <= reqIn.chipSel;
    end
  end

  // Bus pins come from flip-flops; the command strobe covers the access phase only.
  wire active = state_next != PH_IDLE;
  wire strobeNext = state_next == PH_ACCESS;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busAddr <= '0;
      busCs <= '0;
      busRdStrobe <= 1'b0;
      busWrStrobe <= 1'b0;
      busDataOut <= '0;
      busDataOe <= 1'b0;
    end else begin
      busAddr <= accept ? reqIn.addr : req_reg.addr;
      busCs <= active ? (CS_N'(1) << (accept ? reqIn.chipSel : req_reg.chipSel)) : '0;
      busRdStrobe <= strobeNext && !req_reg.write;
      busWrStrobe <= strobeNext && req_reg.write;
      busDataOut <= accept ? reqIn.wdata : req_reg.wdata;
      busDataOe <= active && (accept ? reqIn.write : req_reg.write);
    end
  end

  // Completion pulse and read data taken when the access phase ends.
  wire accDone = (state_reg == PH_ACCESS) && accessEnd;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneValid <= 1'b0;
      rdData <= '0;
    end else begin
      doneValid <= accDone;
      if (accDone && !req_reg.write) begin
        rdData <= dataSync;
      end
    end
  end

  // Helper: cycles spent so far in the current phase.
  logic [CNT_W-1:0] runLen_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      runLen_reg <= CNT_RESET;
    end else begin
      runLen_reg <= (state_next != state_reg) ? CNT_RESET : runLen_reg + 6'h01;
    end
  end
  wire leaving = state_next != state_reg;

  property p_order;
    @(posedge ref_clk) disable iff (!rst_n)
    leaving |-> state_next > state_reg || state_next == PH_IDLE;
  endproperty
  a_order: assert property (p_order) else $error("Phase order broken.");

  property p_cmd_len;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_CMD && leaving) |-> runLen_reg + 6'h01 == cmdLen;
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("Command delay length wrong.");

  property p_acc_min;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_ACCESS && leaving) |-> runLen_reg + 6'h01 >= accLen;
  endproperty
  a_acc_min: assert property (p_acc_min) else $error("Access phase too short.");

  property p_setup_max;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_SETUP) |-> runLen_reg < SETUP_MAX;
  endproperty
  a_setup_max: assert property (p_setup_max) else $error("Setup phase over five cycles.");

  property p_setup_same;
    @(posedge ref_clk) disable iff (!rst_n)
    (accept && !winChange) |=> cnt_reg == {5'h00, $past(newCfg.setupLong)};
  endproperty
  a_setup_same: assert property (p_setup_same) else $error("Setup extended wrongly.");

  property p_wrsu_len;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_WRSU) |=> state_reg == PH_ACCESS;
  endproperty
  a_wrsu_len: assert property (p_wrsu_len) else $error("Write setup not one cycle.");

  property p_hold_stable;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_HOLD) |-> $stable(busAddr) && $stable(busDataOut);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("Bus moved in hold.");

  property p_hold_len;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_HOLD && leaving) |-> runLen_reg + 6'h01 == holdLen;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("Hold length wrong.");

  property p_ready_wait;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_ACCESS && leaving && cur_reg.readyEn) |-> readySync;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("Access ended without ready.");

  property p_done;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == PH_ACCESS && leaving) |=> doneValid ##1 !doneValid;
  endproperty
  a_done: assert property (p_done) else $error("Completion pulse wrong.");

endmodule

/* File: rtl/ebc_pkg.sv */
// Package with the phase timing constants, types and states of the external bus cycle controller.
package ebc_pkg;

  // One phase count unit is one system clock period.
  localparam int SYS_PERIOD_NS = 40;
  localparam int PHASE_UNIT_NS = 40;
  localparam int PHASE_UNIT_CYC = (PHASE_UNIT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // Widths of the bus and of the chip select index.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CS_N = 4;
  localparam int CS_W = 2;
  localparam int CNT_W = 6;

  // Phase length limits in system clock cycles.
  localparam logic [CNT_W-1:0] SETUP_BASE_MIN = 6'h01;
  localparam logic [CNT_W-1:0] ACCESS_MIN = 6'h01;
  localparam logic [CNT_W-1:0] SETUP_MAX = 6'h05;
  localparam logic [CNT_W-1:0] ACCESS_MAX = 6'h20;

  // Values after reset.
  localparam logic [CS_W-1:0] LAST_CS_RESET = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;

  // Timing configuration of one chip select.
  typedef struct packed {
    logic setupLong;        // Address setup 1 (0) or 2 (1) cycles.
    logic [1:0] setupExt;   // Extra setup cycles on a window change.
    logic [1:0] cmdDelay;   // Command delay cycles.
    logic wrSetup;          // Write setup or tristate turnaround cycle.
    logic [4:0] accessLen;  // Access cycles minus one.
    logic [1:0] holdLen;    // Address and write data hold cycles.
    logic readyEn;          // Access end waits for the ready handshake.
  } ebc_timing_t;

  // One bus cycle request from the core.
  typedef struct packed {
    logic write;
    logic [CS_W-1:0] chipSel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebc_req_t;

  // Bus cycle phases.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_SETUP = 3'b001,
    PH_CMD = 3'b010,
    PH_WRSU = 3'b011,
    PH_ACCESS = 3'b100,
    PH_HOLD = 3'b101
  } ebc_phase_t;

endpackage

/* File: rtl/ebc_sync2.sv */
// Two flip-flop synchroniser for levels entering the system clock domain.
module ebc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      syncOut <= '0;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end

endmodule

/* File: tb/ebc_ext_model.sv */
// Behavioural model of the external memory or peripheral on the parallel bus.
module ebc_ext_model (
  // Link clock of the external module and reset.
  input wire logic linkClk,
  input wire logic rst_n,
  // Bus pins seen from the module.
  input wire logic [ebc_pkg::CS_N-1:0] busCs,
  input wire logic busRdStrobe,
  input wire logic busWrStrobe,
  input wire logic busDataOe,
  // Test controls: ready delay in link cycles and the word to return.
  input wire logic [3:0] waitLen,
  input wire logic [ebc_pkg::DATA_W-1:0] memVal,
  // Answer pins.
  output logic [ebc_pkg::DATA_W-1:0] busDataIn,
  output logic busReady
);
  import ebc_pkg::*;
  logic [3:0] waitCnt;

  // Ready rises waitLen link cycles into the strobe and falls when it ends.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
      busReady <= 1'b0;
    end else if (busRdStrobe || busWrStrobe) begin
      if (waitCnt < waitLen) waitCnt <= waitCnt + 4'h1;
      busReady <= (waitCnt >= waitLen);
    end else begin
      waitCnt <= 4'h0;
      busReady <= 1'b0;
    end
  end

  // Data only while selected for a read; otherwise the inverse, so stale values never match.
  assign busDataIn = (|busCs && !busDataOe) ? memVal : ~memVal;
endmodule

/* File: tb/external_bus_cycle_phases_tb.sv */
// Self-checking bench for the external bus cycle phase controller.
module external_bus_cycle_phases_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ebc_pkg::*;
  typedef struct {
    int setup, cmd, wrsu, acc, hold;
    logic exact, wr;
    logic [1:0] cs;
    logic [15:0] addr, data;
  } ebc_note_t;
  logic ref_clk = 0, rst_n = 0, linkClk = 0, refClkEnable = 0, reqValid = 0;
  ebc_timing_t [CS_N-1:0] cfg = '0;
  ebc_req_t req = '0;
  logic [3:0] waitLen = 4'h0;
  logic [15:0] memVal = 16'h0000, rdData, busAddr, busDataOut, busDataIn, lastAddr, lastData;
  logic bus_reference_clock_output, fastDrive, reqReady, doneValid, rdStb, wrStb, dataOe, busReady;
  logic [CS_N-1:0] busCs;
  logic [31:0] r;
  ebc_phase_t phase, lastPh = PH_IDLE;
  ebc_note_t notes[$], cur, live;
  int err_total = 0, n_tests = 0, seed = 76398, cnt[8] = '{default: 0}, i, k;
  logic [CS_W-1:0] prevCs = 2'h0;
  logic haveNote = 0, cycEnd = 0;

  // System clock at 25 MHz, link clock at 64 ns with an unrelated phase.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #7;
    forever #32 linkClk = ~linkClk;
  end

  ebc_phase_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .linkClk(linkClk),
    .chip_select_timing_config(cfg), .refClkEnable(refClkEnable),
    .clock_output_signal(bus_reference_clock_output), .refClkFastDrive(fastDrive), .reqValid(reqValid),
    .reqIn(req), .reqReady(reqReady), .doneValid(doneValid), .rdData(rdData),
    .busAddr(busAddr), .busCs(busCs), .busRdStrobe(rdStb), .busWrStrobe(wrStb),
    .busDataOut(busDataOut), .busDataOe(dataOe), .busDataIn(busDataIn),
    .busReady(busReady), .phase(phase));

  ebc_ext_model partner (.linkClk(linkClk), .rst_n(rst_n), .busCs(busCs),
    .busRdStrobe(rdStb), .busWrStrobe(wrStb), .busDataOe(dataOe), .waitLen(waitLen),
    .memVal(memVal), .busDataIn(busDataIn), .busReady(busReady));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Wait for idle, note the expected phase lengths, then offer one request.
  task automatic doCycle(input logic wr, input logic [CS_W-1:0] cs, input int acc,
                         input logic [3:0] wt);
    ebc_note_t n;
    int j;
    j = 0;
    do begin
      @(negedge ref_clk);
      j++;
    end while (reqReady !== 1'b1 && j < 3000);
    if (j >= 3000) begin
      err_total++;
      summarize();
    end
    n.setup = 1 + cfg[cs].setupLong + ((cs != prevCs) ? cfg[cs].setupExt : 0);
    n.cmd = cfg[cs].cmdDelay;
    n.wrsu = cfg[cs].wrSetup;
    n.hold = cfg[cs].holdLen;
    n.exact = !cfg[cs].readyEn;
    n.acc = n.exact ? cfg[cs].accessLen + 1 : acc;
    n.wr = wr;
    n.cs = cs;
    n.addr = 16'($random(seed));
    n.data = 16'($random(seed));
    prevCs = cs;
    notes.push_back(n);
    @(posedge ref_clk);
    req <= '{wr, cs, n.addr, n.data};
    memVal <= n.data;
    waitLen <= wt;
    reqValid <= 1'b1;
    @(posedge ref_clk);
    reqValid <= 1'b0;
  endtask

  // Reference clock gating, looked at mid high and mid low.
  task automatic clkCheck(input logic en);
    @(posedge ref_clk);
    refClkEnable <= en;
    @(posedge ref_clk);
    #5;
    check("clock out high", bus_reference_clock_output, en);
    check("fast drive", fastDrive, en);
    @(negedge ref_clk);
    #5;
    check("clock out low", bus_reference_clock_output, 1'b0);
  endtask

  // Count phase lengths at mid cycle; a done pulse takes the oldest note.
  always @(negedge ref_clk) begin
    if (rst_n) begin
      if (phase != lastPh && phase != PH_IDLE) check("phase order", phase > lastPh, 1'b1);
      check("core ready", reqReady, phase == PH_IDLE);
      // Between cycles chip selects, data drive and both strobes must be released.
      if (phase == PH_IDLE) check("idle pins", {busCs, dataOe, rdStb, wrStb}, 7'h00);
      if (phase != PH_IDLE) begin
        cnt[phase]++;
        lastAddr = busAddr;
        lastData = busDataOut;
        // The oldest note is the cycle in flight until its done pulse moves it to cur.
        live = haveNote ? cur : notes[0];
        check("chip select", busCs, 4'h1 << live.cs);
        check("write drive", dataOe, live.wr);
        check("write strobe", wrStb, live.wr && phase == PH_ACCESS);
        check("read strobe", rdStb, !live.wr && phase == PH_ACCESS);
        check("address held", busAddr, live.addr);
        if (live.wr) check("write data held", busDataOut, live.data);
      end else if (lastPh != PH_IDLE) begin
        cycEnd = 1'b1;
      end
      if (doneValid === 1'b1) begin
        if (notes.size() == 0) begin
          check("spare done", 1'b1, 1'b0);
        end else begin
          cur = notes.pop_front();
          haveNote = 1'b1;
          if (!cur.wr) check("read data", rdData, cur.data);
        end
      end
      if (cycEnd && haveNote) begin
        check("setup", cnt[1], cur.setup);
        check("command", cnt[2], cur.cmd);
        check("write setup", cnt[3], cur.wrsu);
        if (cur.exact) check("access", cnt[4], cur.acc);
        else check("ready access", cnt[4] >= cur.acc, 1'b1);
        check("hold", cnt[5], cur.hold);
        check("address", lastAddr, cur.addr);
        if (cur.wr) check("write data", lastData, cur.data);
        cnt = '{default: 0};
        cycEnd = 1'b0;
        haveNote = 1'b0;
      end
      lastPh = phase;
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    clkCheck(1'b1);
    clkCheck(1'b0);
    // Shortest phases, then longest with a window change, then a read in the same window.
    cfg[0] <= '0;
    cfg[1] <= '{1'b1, 2'h3, 2'h3, 1'b1, 5'h1F, 2'h3, 1'b0};
    doCycle(1'b1, 2'h0, 0, 4'h0);
    doCycle(1'b1, 2'h1, 0, 4'h0);
    doCycle(1'b0, 2'h1, 0, 4'h0);
    // Random settings and traffic; access kept at 5 or more so read data can settle.
    for (i = 0; i < 48; i++) begin
      if (i % 12 == 0) begin
        for (k = 0; k < CS_N; k++) begin
          r = $random(seed);
          cfg[k] <= ebc_timing_t'({r[13:1] | 13'h0010, 1'b0});
        end
      end
      r = $random(seed);
      doCycle(r[0], r[2:1], 0, 4'h0);
    end
    // Access stretched by ready, answered promptly and then slowly.
    cfg[2] <= '{1'b0, 2'h0, 2'h1, 1'b0, 5'h07, 2'h1, 1'b1};
    doCycle(1'b0, 2'h2, 8, 4'h0);
    doCycle(1'b1, 2'h2, 19, 4'hC);
    k = 0;
    while ((notes.size() != 0 || phase != PH_IDLE) && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 3000) err_total++;
    repeat (2) @(negedge ref_clk);
    summarize();
  end
endmodule
